// ### qvs_valley_ctrl.sv
// Purpose: quasi-resonant turn-on decision, blanking, starter and restart charge select
// Assumes: comparators and supply monitors are asynchronous; turn_off_req and
//          fault_shutdown come from same-clock logic
// Notes:   current limit, overvoltage and burst handling live elsewhere
// Operation
// - trigger accepted only after arm crossing
// - fixed delay between trigger and turn-on
// - oscillator 136 or 225 kHz by variant
// - oscillator period restarts at every turn-on
// - trigger after full period turns switch on
// - early trigger ignored, wait for re-arm
// - sense edges ignored during post-turn-off blanking
// - inhibit extends until blanking ends
// - blanking is 2,5 us or 6,3 us
// - above 1 V short blanking, else long
// - unarmed sense runs fixed starter frequency
// - armed sense times turn-on from demagnetization
// - sense stuck above arm gives minimum frequency
// - after fault recharge only below restart level
// - reduced charge current after fault
// - 1 V sample in window after strobe delay
// - gate held low under supply lockout
`timescale 1ns/1ps
module qvs_valley_ctrl
	import qvs_pkg::*;
#(
	parameter bit               VARIANT_HIGH    = 1'b0,
	parameter logic [CNT_W-1:0] STARTER_PERIOD  = qvs_pkg::STARTER_CYCLES,
	parameter logic [CNT_W-1:0] FALLBACK_PERIOD = qvs_pkg::FALLBACK_CYCLES
) (
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst_n,
	// demag sense comparators (asynchronous)
	input  wire logic arm_threshold,
	input  wire logic trigger_threshold,
	input  wire logic above_one_volt,
	// supply monitors (asynchronous)
	input  wire logic supply_lockout,
	input  wire logic restart_supply_level,
	input  wire logic hv_above_start,
	// same-clock control
	input  wire logic turn_off_req,
	input  wire logic fault_shutdown,
	// power switch
	output logic      gate_drive,
	// startup charge source
	output logic      startup_charge_current,
	output logic      charge_reduced,
	// status
	output logic      blank_long,
	output logic      qr_mode,
	output logic      fallback_active
);
	import qvs_pkg::*;

	localparam logic [CNT_W-1:0] OSC_PERIOD = VARIANT_HIGH ? OSC_HIGH_CYCLES : OSC_LOW_CYCLES;

	logic [SYNC_W-1:0] sync_lvl;
	logic              arm_s;
	logic              trig_s;
	logic              one_v_s;
	logic              lockout_s;
	logic              restart_s;
	logic              hv_s;
	logic              arm_d;
	logic              trig_d;
	logic              lockout_d;

	qvs_sync #(
		.WIDTH   (SYNC_W),
		.RST_VAL (SYNC_RST)
	) u_sync (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.async_in ({supply_lockout, hv_above_start, restart_supply_level,
			above_one_volt, trigger_threshold, arm_threshold}),
		.sync_out (sync_lvl)
	);

	assign arm_s     = sync_lvl[0];
	assign trig_s    = sync_lvl[1];
	assign one_v_s   = sync_lvl[2];
	assign restart_s = sync_lvl[3];
	assign hv_s      = sync_lvl[4];
	assign lockout_s = sync_lvl[5];

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			arm_d     <= 1'b0;
			trig_d    <= 1'b0;
			lockout_d <= 1'b1;
		end else begin
			arm_d     <= arm_s;
			trig_d    <= trig_s;
			lockout_d <= lockout_s;
		end
	end

	qvs_state_type    state;
	qvs_state_type    next_state;
	logic [CNT_W-1:0] on_cnt;
	logic [CNT_W-1:0] off_cnt;
	logic [CNT_W-1:0] dly_cnt;
	logic [CNT_W-1:0] stuck_cnt;
	logic [CNT_W-1:0] blank_len;
	logic             armed;
	logic             arm_seen;
	logic             fault_latched;
	logic             win_high;
	logic             hold_off;
	logic             blanking;
	logic             osc_done;
	logic             arm_rise;
	logic             trig_fall;
	logic             accept_trig;
	logic             ignore_trig;
	logic             starter_fire;
	logic             fallback_fire;
	logic             turn_on;
	logic             turn_off;

	assign hold_off  = lockout_s | fault_latched;
	assign blank_len = blank_long ? BLANK_LONG_CYCLES : BLANK_SHORT_CYCLES;
	assign blanking  = (off_cnt < blank_len);
	assign osc_done  = (on_cnt >= OSC_PERIOD);
	// edges only count once blanking is over, so leakage ringing is masked
	assign arm_rise  = arm_s & ~arm_d & (state == QVS_OFF) & ~blanking;
	assign trig_fall = ~trig_s & trig_d & (state == QVS_OFF) & ~blanking;

	// the inhibit is the later of oscillator end and blanking end
	assign accept_trig   = trig_fall & armed & osc_done;
	assign ignore_trig   = trig_fall & armed & ~osc_done;
	assign starter_fire  = (state == QVS_OFF) & ~blanking & ~arm_seen & ~fallback_active
		& osc_done & (on_cnt >= STARTER_PERIOD);
	assign fallback_fire = (state == QVS_OFF) & ~blanking & fallback_active
		& (on_cnt >= FALLBACK_PERIOD);

	always_comb begin
		next_state = state;
		unique case (state)
			QVS_LOCKED: begin
				if (!hold_off) begin
					next_state = QVS_OFF;
				end
			end
			QVS_OFF: begin
				if (accept_trig) begin
					next_state = QVS_DELAY;
				end else if (starter_fire || fallback_fire) begin
					next_state = QVS_ON;
				end
			end
			QVS_DELAY: begin
				if (dly_cnt >= TURN_ON_DELAY_CYCLES - 1'b1) begin
					next_state = QVS_ON;
				end
			end
			QVS_ON: begin
				if (turn_off_req) begin
					next_state = QVS_OFF;
				end
			end
		endcase
		if (hold_off || fault_shutdown) begin
			next_state = QVS_LOCKED;
		end
	end

	assign turn_on  = (next_state == QVS_ON) & (state != QVS_ON);
	assign turn_off = (state == QVS_ON) & (next_state != QVS_ON);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= QVS_LOCKED;
		end else begin
			state <= next_state;
		end
	end

	// gate follows the on state; lockout forces it low
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			gate_drive <= 1'b0;
		end else begin
			gate_drive <= (next_state == QVS_ON);
		end
	end

	// oscillator period counts from the latest turn-on
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			on_cnt <= '0;
		end else if (state == QVS_LOCKED) begin
			on_cnt <= '0;
		end else if (turn_on) begin
			on_cnt <= '0;
		end else if (on_cnt != CNT_MAX) begin
			on_cnt <= on_cnt + 1'b1;
		end
	end

	// time since turn-off; saturated while locked so first start needs no blanking
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			off_cnt <= CNT_MAX;
		end else if (state == QVS_LOCKED) begin
			off_cnt <= CNT_MAX;
		end else if (turn_off) begin
			off_cnt <= '0;
		end else if (off_cnt != CNT_MAX) begin
			off_cnt <= off_cnt + 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			dly_cnt <= '0;
		end else if (state == QVS_DELAY) begin
			dly_cnt <= dly_cnt + 1'b1;
		end else begin
			dly_cnt <= '0;
		end
	end

	// arm state: set by rising crossing, spent by any trigger or turn-on
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			armed <= 1'b0;
		end else if (state != QVS_OFF) begin
			armed <= 1'b0;
		end else if (arm_rise) begin
			armed <= 1'b1;
		end else if (ignore_trig) begin
			armed <= 1'b0;
		end
	end

	// any arming since turn-on hands timing over to demagnetization
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			arm_seen <= 1'b0;
		end else if (arm_rise) begin
			arm_seen <= 1'b1;
		end else if (turn_on || state == QVS_LOCKED) begin
			arm_seen <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			qr_mode <= 1'b0;
		end else if (state == QVS_LOCKED) begin
			qr_mode <= 1'b0;
		end else if (turn_on) begin
			qr_mode <= arm_seen;
		end
	end

	// stuck detection: a sense level high for a full minimum period
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stuck_cnt <= '0;
		end else if (!arm_s || state == QVS_LOCKED) begin
			stuck_cnt <= '0;
		end else if (stuck_cnt != CNT_MAX) begin
			stuck_cnt <= stuck_cnt + 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fallback_active <= 1'b0;
		end else if (!arm_s || state == QVS_LOCKED) begin
			fallback_active <= 1'b0;
		end else if (stuck_cnt >= FALLBACK_PERIOD) begin
			fallback_active <= 1'b1;
		end
	end

	// strobe window: any high sample inside it picks short blanking
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			win_high <= 1'b0;
		end else if (turn_off) begin
			win_high <= 1'b0;
		end else if (state == QVS_OFF && off_cnt >= STROBE_START_CYCLES
			&& off_cnt < STROBE_END_CYCLES && one_v_s) begin
			win_high <= 1'b1;
		end
	end

	// long blanking from reset, as the output is low at power-up
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			blank_long <= 1'b1;
		end else if (state == QVS_OFF && off_cnt == STROBE_END_CYCLES) begin
			blank_long <= ~(win_high | one_v_s);
		end
	end

	// fault latch: set wins over the clear at lockout release
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fault_latched <= 1'b0;
		end else if (fault_shutdown) begin
			fault_latched <= 1'b1;
		end else if (lockout_d && !lockout_s) begin
			fault_latched <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			charge_reduced <= 1'b0;
		end else begin
			charge_reduced <= fault_latched | fault_shutdown;
		end
	end

	// charge source: off while switching or with low HV input; after a
	// fault it waits for the restart level, then holds until lockout ends
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			startup_charge_current <= 1'b0;
		end else if (!lockout_s || !hv_s) begin
			startup_charge_current <= 1'b0;
		end else if (!fault_latched || restart_s) begin
			startup_charge_current <= 1'b1;
		end
	end

endmodule // qvs_valley_ctrl

// ### qvs_pkg.sv
// Purpose: shared constants and types for the valley switch turn-on control
// Assumes: 125 MHz mclk; times held in ns, counts derived from them
// Notes:   counts below are least times and round up to whole cycles; the strobe window is a longest time and rounds down
package qvs_pkg;

	localparam int CLK_MHZ = 125;
	localparam int CLK_HZ  = 125_000_000;
	localparam int CNT_W   = 16;

	// least time in ns to cycles, rounded up, never below one
	function automatic int ns_to_cyc_min(input int t_ns);
		int c;
		c = (t_ns * CLK_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction

	// longest time in ns to cycles, rounded down, never below one
	function automatic int ns_to_cyc_max(input int t_ns);
		int c;
		c = (t_ns * CLK_MHZ) / 1000;
		return (c < 1) ? 1 : c;
	endfunction

	// period of a frequency in cycles, rounded up so the limit is never beaten
	function automatic int hz_to_cyc(input int f_hz);
		return (CLK_HZ + f_hz - 1) / f_hz;
	endfunction

	// frequency limits of the oscillator variants
	localparam int OSC_LOW_HZ  = 136_000;
	localparam int OSC_HIGH_HZ = 225_000;
	// starter and fallback frequencies; plain defaults
	localparam int STARTER_HZ  = 22_000;
	localparam int FALLBACK_HZ = 13_000;

	localparam logic [CNT_W-1:0] OSC_LOW_CYCLES  = CNT_W'(hz_to_cyc(OSC_LOW_HZ));
	localparam logic [CNT_W-1:0] OSC_HIGH_CYCLES = CNT_W'(hz_to_cyc(OSC_HIGH_HZ));
	localparam logic [CNT_W-1:0] STARTER_CYCLES  = CNT_W'(hz_to_cyc(STARTER_HZ));
	localparam logic [CNT_W-1:0] FALLBACK_CYCLES = CNT_W'(hz_to_cyc(FALLBACK_HZ));

	// blanking lengths after turn-off
	localparam int BLANK_SHORT_NS = 2500;
	localparam int BLANK_LONG_NS  = 6300;
	localparam logic [CNT_W-1:0] BLANK_SHORT_CYCLES = CNT_W'(ns_to_cyc_min(BLANK_SHORT_NS));
	localparam logic [CNT_W-1:0] BLANK_LONG_CYCLES  = CNT_W'(ns_to_cyc_min(BLANK_LONG_NS));

	// valley landing delay after an accepted trigger; plain default
	localparam int TURN_ON_DELAY_NS = 200;
	localparam logic [CNT_W-1:0] TURN_ON_DELAY_CYCLES = CNT_W'(ns_to_cyc_min(TURN_ON_DELAY_NS));

	// strobe window for the 1 V sample; plain defaults
	localparam int STROBE_DELAY_NS  = 2000;
	localparam int STROBE_WINDOW_NS = 100;
	localparam logic [CNT_W-1:0] STROBE_START_CYCLES = CNT_W'(ns_to_cyc_min(STROBE_DELAY_NS));
	localparam logic [CNT_W-1:0] STROBE_END_CYCLES   =
		CNT_W'(ns_to_cyc_min(STROBE_DELAY_NS) + ns_to_cyc_max(STROBE_WINDOW_NS));

	localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

	// synchroniser lanes and reset levels (lockout asserted at reset)
	localparam int         SYNC_W   = 6;
	localparam logic [5:0] SYNC_RST = 6'h20;

	typedef enum logic [1:0] {
		QVS_LOCKED,
		QVS_OFF,
		QVS_DELAY,
		QVS_ON
	} qvs_state_type;

endpackage

// ### qvs_sync.sv
// Purpose: three-stage synchroniser for asynchronous comparator levels
// Assumes: single clock mclk, asynchronous active-low reset
// Notes:   output follows once stages two and three agree
`timescale 1ns/1ps
module qvs_sync #(
	parameter int                 WIDTH   = 1,
	parameter logic [WIDTH-1:0]   RST_VAL = '0
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             rst_n,
	// levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	// stage1 feeds stage2 only, to keep metastability contained
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= RST_VAL;
			stage2 <= RST_VAL;
			stage3 <= RST_VAL;
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sync_out <= RST_VAL;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (stage2[i] == stage3[i]) begin
					sync_out[i] <= stage3[i];
				end
			end
		end
	end

endmodule // qvs_sync

// ### qvs_valley_ctrl_asserts.sv
// Purpose: port checks for the valley switch turn-on control
// Assumes: one clock, async low reset, async inputs seen four edges late
// Notes:   gate spacing measured from gate edges seen at the ports
`timescale 1ns/1ps
module qvs_valley_ctrl_asserts #(
	parameter bit                        VARIANT_HIGH    = 1'b0,
	parameter logic [qvs_pkg::CNT_W-1:0] STARTER_PERIOD  = qvs_pkg::STARTER_CYCLES,
	parameter logic [qvs_pkg::CNT_W-1:0] FALLBACK_PERIOD = qvs_pkg::FALLBACK_CYCLES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// inputs
	input wire logic arm_threshold,
	input wire logic trigger_threshold,
	input wire logic above_one_volt,
	input wire logic supply_lockout,
	input wire logic restart_supply_level,
	input wire logic hv_above_start,
	input wire logic turn_off_req,
	input wire logic fault_shutdown,
	// outputs
	input wire logic gate_drive,
	input wire logic startup_charge_current,
	input wire logic charge_reduced,
	input wire logic blank_long,
	input wire logic qr_mode,
	input wire logic fallback_active
);
	import qvs_pkg::*;
	localparam logic [CNT_W-1:0] OSC_P = VARIANT_HIGH ? OSC_HIGH_CYCLES : OSC_LOW_CYCLES;
	logic [CNT_W-1:0] since_on;
	logic [CNT_W-1:0] since_off;
	logic             gate_q;
	// saturating, so a long lockout never wraps into a short count
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			gate_q    <= 1'b0;
			since_on  <= '0;
			since_off <= CNT_MAX;
		end else begin
			gate_q    <= gate_drive;
			since_on  <= (gate_drive && !gate_q) ? 16'h0001 : since_on + (since_on != CNT_MAX);
			since_off <= (!gate_drive && gate_q) ? 16'h0001 : since_off + (since_off != CNT_MAX);
		end
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	a_lock_gate_low: assert property (supply_lockout [*7] |-> !gate_drive)
		else $error("gate high under lockout");
	a_gate_stands: assert property ((!supply_lockout [*7]) ##0 (gate_drive && !turn_off_req && !fault_shutdown)
		|=> gate_drive)
		else $error("gate dropped without cause");
	a_fault_gate_off: assert property (fault_shutdown |=> !gate_drive)
		else $error("gate high after fault");
	a_blank_min: assert property ($rose(gate_drive) |->
		since_off >= (blank_long ? BLANK_LONG_CYCLES : BLANK_SHORT_CYCLES))
		else $error("turn-on inside blanking");
	a_osc_limit: assert property ($rose(gate_drive) |-> since_on >= OSC_P)
		else $error("turn-on faster than oscillator limit");
	a_fallback_min: assert property ($rose(gate_drive) && fallback_active |-> since_on >= FALLBACK_PERIOD)
		else $error("fallback period too short");
	a_charge_run_off: assert property (!supply_lockout [*7] |-> !startup_charge_current)
		else $error("charging while running");
	a_charge_hv_low: assert property (!hv_above_start [*7] |-> !startup_charge_current)
		else $error("charging with low input");
	a_fault_reduce: assert property (fault_shutdown |-> ##[1:3] charge_reduced)
		else $error("reduced charge not selected");
	c_fallback: cover property ($rose(gate_drive) && fallback_active);
	c_short_blank: cover property ($rose(gate_drive) && !blank_long && qr_mode);
	c_restart: cover property (charge_reduced && startup_charge_current);
endmodule // qvs_valley_ctrl_asserts

bind qvs_valley_ctrl qvs_valley_ctrl_asserts #(.VARIANT_HIGH(VARIANT_HIGH), .STARTER_PERIOD(STARTER_PERIOD),
	.FALLBACK_PERIOD(FALLBACK_PERIOD)) i_asserts (.mclk(mclk), .rst_n(rst_n), .arm_threshold(arm_threshold),
	.trigger_threshold(trigger_threshold), .above_one_volt(above_one_volt), .supply_lockout(supply_lockout),
	.restart_supply_level(restart_supply_level), .hv_above_start(hv_above_start), .turn_off_req(turn_off_req),
	.fault_shutdown(fault_shutdown), .gate_drive(gate_drive), .startup_charge_current(startup_charge_current),
	.charge_reduced(charge_reduced), .blank_long(blank_long), .qr_mode(qr_mode), .fallback_active(fallback_active));

// ### qvs_flyback_model.sv
// Purpose: auxiliary winding sense seen through the comparators
// Assumes: sense negative while switch on; plateau then ringing when off
// Notes:   ringing never decays, so valleys last until t_off saturates at 4095 cycles
`timescale 1ns/1ps
module qvs_flyback_model (
	// clock and switch
	input  wire logic        mclk,
	input  wire logic        gate_drive,
	// 0 no sense, 1 demag and ringing, 2 stuck high
	input  wire logic [1:0]  mode,
	input  wire logic        amp_hi,
	input  wire logic [11:0] demag_len,
	input  wire logic [11:0] ring_half,
	// comparator levels
	output logic             arm_threshold,
	output logic             trigger_threshold,
	output logic             above_one_volt
);
	logic [11:0] t_off = '0;
	logic        sense_hi;
	// plain always: the declaration gives the start value, so no reset is needed
	always @(posedge mclk) begin
		t_off <= gate_drive ? '0 : t_off + (t_off != 12'hfff);
	end
	always_comb begin
		if (mode == 2'h2)
			sense_hi = 1'b1;
		else if (mode == 2'h0 || gate_drive)
			sense_hi = 1'b0;
		else if (t_off < demag_len)
			sense_hi = 1'b1;
		else
			sense_hi = ((t_off - demag_len) / ring_half) % 2 == 1;
	end
	// trigger level sits below arm level, so both cross together here
	assign arm_threshold     = sense_hi;
	assign trigger_threshold = sense_hi;
	assign above_one_volt    = sense_hi && amp_hi;
endmodule // qvs_flyback_model

// ### qvs_valley_ctrl_tb.sv
// Purpose: scenario bench for the valley switch turn-on control
// Assumes: 125 MHz mclk, low variant, shortened starter and fallback
// Notes:   on-time ended by the bench after on_len cycles
`timescale 1ns/1ps
module qvs_valley_ctrl_tb;
	import qvs_pkg::*;
	logic        mclk = 1'b0;
	logic        rst_n, supply_lockout, restart_supply_level, hv_above_start, fault_shutdown;
	logic        turn_off_req = 1'b0;
	logic        prev_g = 1'b0;
	logic        arm_threshold, trigger_threshold, above_one_volt;
	logic        gate_drive, startup_charge_current, charge_reduced, blank_long, qr_mode, fallback_active;
	logic [1:0]  mode;
	logic        amp_hi;
	logic [11:0] demag_len, ring_half;
	int          on_len, on_cnt, pc, oc, per_q, off_q, n_on, n0, err_count, n_checks;
	always #4 mclk = ~mclk;
	// starter kept above on-time plus long blanking, so masked arm edges cannot let it win
	qvs_valley_ctrl #(.VARIANT_HIGH(1'b0), .STARTER_PERIOD(16'h0800), .FALLBACK_PERIOD(16'h07d0)) i_dut (
		.mclk(mclk), .rst_n(rst_n), .arm_threshold(arm_threshold), .trigger_threshold(trigger_threshold),
		.above_one_volt(above_one_volt), .supply_lockout(supply_lockout), .restart_supply_level(restart_supply_level),
		.hv_above_start(hv_above_start), .turn_off_req(turn_off_req), .fault_shutdown(fault_shutdown),
		.gate_drive(gate_drive), .startup_charge_current(startup_charge_current), .charge_reduced(charge_reduced),
		.blank_long(blank_long), .qr_mode(qr_mode), .fallback_active(fallback_active));
	qvs_flyback_model i_model (.mclk(mclk), .gate_drive(gate_drive), .mode(mode), .amp_hi(amp_hi),
		.demag_len(demag_len), .ring_half(ring_half), .arm_threshold(arm_threshold),
		.trigger_threshold(trigger_threshold), .above_one_volt(above_one_volt));
	// ends the on-time and times each switching period
	always @(posedge mclk) begin
		prev_g       <= gate_drive;
		on_cnt       <= gate_drive ? on_cnt + 1 : 0;
		oc           <= gate_drive ? 0 : oc + 1;
		pc           <= (gate_drive && !prev_g) ? 1 : pc + 1;
		turn_off_req <= gate_drive && on_cnt + 1 >= on_len;
		if (gate_drive && !prev_g) begin
			per_q <= pc;
			off_q <= oc;
			n_on  <= n_on + 1;
		end
	end
	function automatic logic near(input int a, input int b);
		return a >= b - 3 && a <= b + 3;
	endfunction
	task automatic end_sim();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic wait_on(input int k, input int lim);
		int s;
		int i;
		s = n_on;
		for (i = 0; i < lim && n_on < s + k; i++)
			@(posedge mclk);
		if (n_on < s + k) begin
			err_count++;
			$display("[ERR] %0t no turn-on", $time);
			end_sim();
		end
	endtask
	initial begin
		{rst_n, supply_lockout, restart_supply_level, fault_shutdown, mode} <= '0;
		{hv_above_start, amp_hi} <= 2'h3;
		demag_len = 12'h190;
		ring_half = 12'h064;
		on_len = 100;
		cyc(4);
		check(gate_drive, 0);
		check({startup_charge_current, charge_reduced, qr_mode, fallback_active}, 0);
		check(blank_long, 1);
		rst_n <= 1'b1;
		wait_on(3, 8000);
		check(per_q >= 2048 && per_q <= 2050, 1);
		check(qr_mode, 0);
		// first valley unarmed, next two early valleys skipped, fourth taken
		mode <= 2'h1;
		wait_on(3, 8000);
		check(near(off_q, 1030), 1);
		check(qr_mode, 1);
		check(blank_long, 0);
		// long on-time, low sense: blanking outlasts the oscillator
		amp_hi <= 1'b0;
		demag_len <= 12'h096;
		on_len <= 700;
		wait_on(3, 8000);
		check(near(off_q, 980), 1);
		check(blank_long, 1);
		mode <= 2'h2;
		wait_on(4, 20000);
		check(fallback_active, 1);
		check(per_q >= 2000 && per_q <= 2002, 1);
		supply_lockout <= 1'b1;
		cyc(8);
		n0 = n_on;
		cyc(3000);
		check(n_on - n0 + gate_drive, 0);
		check(startup_charge_current, 1);
		hv_above_start <= 1'b0;
		cyc(8);
		check(startup_charge_current, 0);
		{hv_above_start, supply_lockout, mode} <= 4'h8;
		wait_on(1, 4000);
		fault_shutdown <= 1'b1;
		cyc(1);
		fault_shutdown <= 1'b0;
		cyc(8);
		check({gate_drive, charge_reduced, startup_charge_current}, 3'h2);
		supply_lockout <= 1'b1;
		cyc(8);
		check(startup_charge_current, 0);
		restart_supply_level <= 1'b1;
		cyc(8);
		check({startup_charge_current, charge_reduced}, 2'h3);
		restart_supply_level <= 1'b0;
		cyc(8);
		check(startup_charge_current, 1);
		supply_lockout <= 1'b0;
		cyc(10);
		check({charge_reduced, startup_charge_current}, 0);
		end_sim();
	end
endmodule // qvs_valley_ctrl_tb
